// ### rtl/dcn_msg_lists.sv
// Message-object pool, per-node linked lists, receive filtering, gateway,
// and transmit selection for two nodes.
// Assumes per-node bit engines hand over whole frames on the same clock.
`timescale 1ns/1ps
`include "dcn_params.svh"

module dcn_msg_lists #(
	parameter int NUM_OBJ = `DCN_NUM_OBJ,
	parameter int OBJ_W   = $clog2(`DCN_NUM_OBJ)
)(
	input  wire logic                   clk_i,                   // 50 MHz clock
	input  wire logic                   sys_rst_i,               // Async reset, high
	input  wire logic                   cmd_valid_i,             // List command strobe
	input  wire dcn_pkg::dcn_cmd_t      cmd_op_i,                // List command
	input  wire logic [OBJ_W-1:0]       cmd_obj_i,               // Object of command
	input  wire logic                   cmd_node_i,              // Target node
	input  wire logic                   wr_valid_i,              // Object write strobe
	input  wire logic [OBJ_W-1:0]       wr_obj_i,                // Object written
	input  wire logic [`DCN_ID_W-1:0]   wr_id_i,                 // Identifier
	input  wire logic [`DCN_ID_W-1:0]   wr_mask_i,               // Acceptance mask
	input  wire logic                   wr_ide_i,                // Extended format
	input  wire logic                   wr_rtr_i,                // Remote frame
	input  wire logic [`DCN_DLC_W-1:0]  wr_dlc_i,                // Length code
	input  wire logic [`DCN_DATA_W-1:0] wr_data_i,               // Payload
	input  wire logic                   wr_rx_en_i,              // Receive enable
	input  wire logic                   wr_tx_req_i,             // Request transmit
	input  wire logic                   wr_gw_en_i,              // Gateway enable
	input  wire logic [OBJ_W-1:0]       wr_gw_dst_i,             // Gateway target
	input  wire logic [OBJ_W-1:0]       rd_obj_i,                // Object read
	output logic [`DCN_ID_W-1:0]        rd_id_o,                 // Read identifier
	output logic [`DCN_DLC_W-1:0]       rd_dlc_o,                // Read length
	output logic [`DCN_DATA_W-1:0]      rd_data_o,               // Read payload
	output logic [`DCN_FLAG_W-1:0]      rd_flags_o,              // Read status
	input  wire logic                   rx_valid_i [`DCN_NUM_NODE], // Frame received
	input  wire logic [`DCN_ID_W-1:0]   rx_id_i [`DCN_NUM_NODE],    // Rx identifier
	input  wire logic                   rx_ide_i [`DCN_NUM_NODE],   // Rx extended
	input  wire logic                   rx_rtr_i [`DCN_NUM_NODE],   // Rx remote
	input  wire logic [`DCN_DLC_W-1:0]  rx_dlc_i [`DCN_NUM_NODE],   // Rx length
	input  wire logic [`DCN_DATA_W-1:0] rx_data_i [`DCN_NUM_NODE],  // Rx payload
	output logic                        rx_hit_o [`DCN_NUM_NODE],   // Frame stored
	output logic                        tx_valid_o [`DCN_NUM_NODE], // Frame offered
	output logic [`DCN_ID_W-1:0]        tx_id_o [`DCN_NUM_NODE],    // Tx identifier
	output logic                        tx_ide_o [`DCN_NUM_NODE],   // Tx extended
	output logic                        tx_rtr_o [`DCN_NUM_NODE],   // Tx remote
	output logic [`DCN_DLC_W-1:0]       tx_dlc_o [`DCN_NUM_NODE],   // Tx length
	output logic [`DCN_DATA_W-1:0]      tx_data_o [`DCN_NUM_NODE],  // Tx payload
	input  wire logic                   tx_done_i [`DCN_NUM_NODE],  // Frame sent
	output logic [OBJ_W:0]              list_cnt_o [`DCN_NUM_NODE]  // List length
);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic dcn_pkg::dcn_own_t own_of(input int n);
		return (n == 1) ? dcn_pkg::DCN_OWN_N1 : dcn_pkg::DCN_OWN_N0;
	endfunction

	// Standard ids sit in the top 11 bits, so one key orders both formats
	function automatic logic [`DCN_ID_W:0] prio_key(input logic [`DCN_ID_W-1:0] id,
			input logic ide);
		return {id, ide};
	endfunction

	function automatic logic acc_hit(input logic [`DCN_ID_W-1:0] rid, input logic ride,
			input logic [`DCN_ID_W-1:0] oid, input logic oide,
			input logic [`DCN_ID_W-1:0] msk);
		return (((rid ^ oid) & msk) == '0) && (ride == oide);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Object and list state

	dcn_pkg::dcn_own_t       own_ff [NUM_OBJ], nxt_own [NUM_OBJ];
	logic [OBJ_W-1:0]        fwd_ff [NUM_OBJ], nxt_fwd [NUM_OBJ];
	logic [OBJ_W-1:0]        bwd_ff [NUM_OBJ], nxt_bwd [NUM_OBJ];
	logic [OBJ_W-1:0]        head_ff [`DCN_NUM_NODE], nxt_head [`DCN_NUM_NODE];
	logic [OBJ_W-1:0]        tail_ff [`DCN_NUM_NODE], nxt_tail [`DCN_NUM_NODE];
	logic [OBJ_W:0]          cnt_ff [`DCN_NUM_NODE], nxt_cnt [`DCN_NUM_NODE];
	logic [`DCN_ID_W-1:0]    id_ff [NUM_OBJ], nxt_id [NUM_OBJ];
	logic [`DCN_ID_W-1:0]    msk_ff [NUM_OBJ], nxt_msk [NUM_OBJ];
	logic                    ide_ff [NUM_OBJ], nxt_ide [NUM_OBJ];
	logic                    rtr_ff [NUM_OBJ], nxt_rtr [NUM_OBJ];
	logic [`DCN_DLC_W-1:0]   dlc_ff [NUM_OBJ], nxt_dlc [NUM_OBJ];
	logic [`DCN_DATA_W-1:0]  dat_ff [NUM_OBJ], nxt_dat [NUM_OBJ];
	logic                    rxen_ff [NUM_OBJ], nxt_rxen [NUM_OBJ];
	logic                    txrq_ff [NUM_OBJ], nxt_txrq [NUM_OBJ];
	logic                    newd_ff [NUM_OBJ], nxt_newd [NUM_OBJ];
	logic                    gwen_ff [NUM_OBJ], nxt_gwen [NUM_OBJ];
	logic [OBJ_W-1:0]        gwd_ff [NUM_OBJ], nxt_gwd [NUM_OBJ];
	logic                    hit_ff [`DCN_NUM_NODE], nxt_hit [`DCN_NUM_NODE];
	logic                    tx_busy_ff [`DCN_NUM_NODE], nxt_tx_busy [`DCN_NUM_NODE];
	logic [OBJ_W-1:0]        tx_obj_ff [`DCN_NUM_NODE], nxt_tx_obj [`DCN_NUM_NODE];
	logic                    rx_fnd, rx_free;
	logic [OBJ_W-1:0]        rx_sel, lo, lp, lx, gd;
	int                      lk;

	always_comb begin : obj_next
		nxt_own = own_ff;   nxt_fwd = fwd_ff;   nxt_bwd = bwd_ff;
		nxt_head = head_ff; nxt_tail = tail_ff; nxt_cnt = cnt_ff;
		nxt_id = id_ff;     nxt_msk = msk_ff;   nxt_ide = ide_ff;
		nxt_rtr = rtr_ff;   nxt_dlc = dlc_ff;   nxt_dat = dat_ff;
		nxt_rxen = rxen_ff; nxt_txrq = txrq_ff; nxt_newd = newd_ff;
		nxt_gwen = gwen_ff; nxt_gwd = gwd_ff;
		rx_fnd = 1'b0; rx_free = 1'b0; rx_sel = '0; gd = '0;
		lo = cmd_obj_i; lp = '0; lx = '0; lk = 0;
		for (int n = 0; n < `DCN_NUM_NODE; n++) begin
			nxt_hit[n] = 1'b0;
			if (tx_done_i[n] && tx_busy_ff[n]) begin
				nxt_txrq[tx_obj_ff[n]] = 1'b0;
			end
		end
		// Receive: lowest empty match first, so equal filters fill in order
		for (int n = 0; n < `DCN_NUM_NODE; n++) begin
			rx_fnd = 1'b0;
			rx_free = 1'b0;
			rx_sel = '0;
			for (int i = NUM_OBJ - 1; i >= 0; i--) begin
				if (own_ff[i] == own_of(n) && rxen_ff[i] &&
						!(wr_valid_i && wr_obj_i == OBJ_W'(i)) &&
						acc_hit(rx_id_i[n], rx_ide_i[n], id_ff[i], ide_ff[i], msk_ff[i])) begin
					if (!newd_ff[i] || !rx_free) begin
						rx_sel = OBJ_W'(i);
						rx_free = !newd_ff[i];
					end
					rx_fnd = 1'b1;
				end
			end
			if (rx_valid_i[n] && rx_fnd) begin
				nxt_id[rx_sel] = rx_id_i[n];
				nxt_ide[rx_sel] = rx_ide_i[n];
				nxt_rtr[rx_sel] = rx_rtr_i[n];
				nxt_dlc[rx_sel] = rx_dlc_i[n];
				nxt_dat[rx_sel] = rx_data_i[n];
				nxt_newd[rx_sel] = 1'b1;
				nxt_hit[n] = 1'b1;
				gd = gwd_ff[rx_sel];
				if (gwen_ff[rx_sel] && own_ff[gd] == own_of(1 - n)) begin
					nxt_id[gd] = rx_id_i[n];
					nxt_ide[gd] = rx_ide_i[n];
					nxt_rtr[gd] = rx_rtr_i[n];
					nxt_dlc[gd] = rx_dlc_i[n];
					nxt_dat[gd] = rx_data_i[n];
					nxt_newd[gd] = 1'b1;
					nxt_txrq[gd] = 1'b1;
				end
			end
		end
		if (wr_valid_i) begin
			nxt_id[wr_obj_i] = wr_id_i;
			nxt_msk[wr_obj_i] = wr_mask_i;
			nxt_ide[wr_obj_i] = wr_ide_i;
			nxt_rtr[wr_obj_i] = wr_rtr_i;
			nxt_dlc[wr_obj_i] = wr_dlc_i;
			nxt_dat[wr_obj_i] = wr_data_i;
			nxt_rxen[wr_obj_i] = wr_rx_en_i;
			nxt_txrq[wr_obj_i] = wr_tx_req_i | nxt_txrq[wr_obj_i];
			nxt_newd[wr_obj_i] = 1'b0;
			nxt_gwen[wr_obj_i] = wr_gw_en_i;
			nxt_gwd[wr_obj_i] = wr_gw_dst_i;
		end
		// List controller: unlink first, then append at tail of target list
		if (cmd_valid_i && cmd_op_i != dcn_pkg::DCN_CMD_NOP) begin
			if (own_ff[lo] != dcn_pkg::DCN_OWN_NONE) begin
				lk = (own_ff[lo] == dcn_pkg::DCN_OWN_N1) ? 1 : 0;
				lp = bwd_ff[lo];
				lx = fwd_ff[lo];
				// End members link to themselves, so a new end gets a self link
				if (head_ff[lk] == lo) nxt_head[lk] = lx;
				else nxt_fwd[lp] = (tail_ff[lk] == lo) ? lp : lx;
				if (tail_ff[lk] == lo) nxt_tail[lk] = lp;
				else nxt_bwd[lx] = (head_ff[lk] == lo) ? lx : lp;
				nxt_cnt[lk] = cnt_ff[lk] - (OBJ_W+1)'(1);
				nxt_own[lo] = dcn_pkg::DCN_OWN_NONE;
				nxt_fwd[lo] = lo;
				nxt_bwd[lo] = lo;
			end
			if (cmd_op_i == dcn_pkg::DCN_CMD_APPEND) begin
				lk = cmd_node_i ? 1 : 0;
				if (nxt_cnt[lk] == '0) begin
					nxt_head[lk] = lo;
					nxt_bwd[lo] = lo;
				end else begin
					nxt_fwd[nxt_tail[lk]] = lo;
					nxt_bwd[lo] = nxt_tail[lk];
				end
				nxt_tail[lk] = lo;
				nxt_fwd[lo] = lo;
				nxt_own[lo] = own_of(lk);
				nxt_cnt[lk] = nxt_cnt[lk] + (OBJ_W+1)'(1);
			end
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin : obj_regs
		if (sys_rst_i) begin
			for (int i = 0; i < NUM_OBJ; i++) begin
				own_ff[i] <= dcn_pkg::DCN_OWN_NONE;
				fwd_ff[i] <= '0;  bwd_ff[i] <= '0;
				id_ff[i] <= '0;   msk_ff[i] <= '0;
				ide_ff[i] <= 1'b0; rtr_ff[i] <= 1'b0;
				dlc_ff[i] <= '0;  dat_ff[i] <= '0;
				rxen_ff[i] <= 1'b0;
				txrq_ff[i] <= 1'b0;
				newd_ff[i] <= 1'b0; gwen_ff[i] <= 1'b0;
				gwd_ff[i] <= '0;
			end
			for (int n = 0; n < `DCN_NUM_NODE; n++) begin
				head_ff[n] <= '0; tail_ff[n] <= '0;
				cnt_ff[n] <= '0;  hit_ff[n] <= 1'b0;
			end
		end else begin
			own_ff <= nxt_own;   fwd_ff <= nxt_fwd;   bwd_ff <= nxt_bwd;
			head_ff <= nxt_head; tail_ff <= nxt_tail; cnt_ff <= nxt_cnt;
			id_ff <= nxt_id;     msk_ff <= nxt_msk;   ide_ff <= nxt_ide;
			rtr_ff <= nxt_rtr;   dlc_ff <= nxt_dlc;   dat_ff <= nxt_dat;
			rxen_ff <= nxt_rxen; txrq_ff <= nxt_txrq; newd_ff <= nxt_newd;
			gwen_ff <= nxt_gwen; gwd_ff <= nxt_gwd;   hit_ff <= nxt_hit;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmit selection, one frame in flight per node

	logic [`DCN_ID_W-1:0]   tx_id_ff [`DCN_NUM_NODE], nxt_tx_id [`DCN_NUM_NODE];
	logic                   tx_ide_ff [`DCN_NUM_NODE], nxt_tx_ide [`DCN_NUM_NODE];
	logic                   tx_rtr_ff [`DCN_NUM_NODE], nxt_tx_rtr [`DCN_NUM_NODE];
	logic [`DCN_DLC_W-1:0]  tx_dlc_ff [`DCN_NUM_NODE], nxt_tx_dlc [`DCN_NUM_NODE];
	logic [`DCN_DATA_W-1:0] tx_dat_ff [`DCN_NUM_NODE], nxt_tx_dat [`DCN_NUM_NODE];
	logic                   tx_fnd;
	logic [OBJ_W-1:0]       tx_sel;

	always_comb begin : tx_next
		nxt_tx_busy = tx_busy_ff; nxt_tx_obj = tx_obj_ff; nxt_tx_id = tx_id_ff;
		nxt_tx_ide = tx_ide_ff;   nxt_tx_rtr = tx_rtr_ff; nxt_tx_dlc = tx_dlc_ff;
		nxt_tx_dat = tx_dat_ff;
		tx_fnd = 1'b0;
		tx_sel = '0;
		for (int n = 0; n < `DCN_NUM_NODE; n++) begin
			tx_fnd = 1'b0;
			tx_sel = '0;
			for (int i = 0; i < NUM_OBJ; i++) begin
				if (own_ff[i] == own_of(n) && txrq_ff[i] && (!tx_fnd ||
						prio_key(id_ff[i], ide_ff[i]) < prio_key(id_ff[tx_sel], ide_ff[tx_sel])))
						begin
					tx_fnd = 1'b1;
					tx_sel = OBJ_W'(i);
				end
			end
			if (tx_busy_ff[n]) begin
				if (tx_done_i[n]) nxt_tx_busy[n] = 1'b0;
			end else if (tx_fnd) begin
				nxt_tx_busy[n] = 1'b1;
				nxt_tx_obj[n] = tx_sel;
				nxt_tx_id[n] = id_ff[tx_sel];
				nxt_tx_ide[n] = ide_ff[tx_sel];
				nxt_tx_rtr[n] = rtr_ff[tx_sel];
				nxt_tx_dlc[n] = dlc_ff[tx_sel];
				nxt_tx_dat[n] = dat_ff[tx_sel];
			end
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin : tx_regs
		if (sys_rst_i) begin
			for (int n = 0; n < `DCN_NUM_NODE; n++) begin
				tx_busy_ff[n] <= 1'b0; tx_obj_ff[n] <= '0; tx_id_ff[n] <= '0;
				tx_ide_ff[n] <= 1'b0;  tx_rtr_ff[n] <= 1'b0;
				tx_dlc_ff[n] <= '0;    tx_dat_ff[n] <= '0;
			end
		end else begin
			tx_busy_ff <= nxt_tx_busy; tx_obj_ff <= nxt_tx_obj; tx_id_ff <= nxt_tx_id;
			tx_ide_ff <= nxt_tx_ide;   tx_rtr_ff <= nxt_tx_rtr;
			tx_dlc_ff <= nxt_tx_dlc;   tx_dat_ff <= nxt_tx_dat;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Object read-back, one cycle latency

	logic [`DCN_ID_W-1:0]   rd_id_ff, nxt_rd_id;
	logic [`DCN_DLC_W-1:0]  rd_dlc_ff, nxt_rd_dlc;
	logic [`DCN_DATA_W-1:0] rd_dat_ff, nxt_rd_dat;
	logic [`DCN_FLAG_W-1:0] rd_flg_ff, nxt_rd_flg;

	always_comb begin : rd_next
		nxt_rd_id = id_ff[rd_obj_i];
		nxt_rd_dlc = dlc_ff[rd_obj_i];
		nxt_rd_dat = dat_ff[rd_obj_i];
		nxt_rd_flg = {own_ff[rd_obj_i], ide_ff[rd_obj_i], rtr_ff[rd_obj_i],
			rxen_ff[rd_obj_i], txrq_ff[rd_obj_i], newd_ff[rd_obj_i]};
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin : rd_regs
		if (sys_rst_i) begin
			rd_id_ff <= '0;
			rd_dlc_ff <= '0;
			rd_dat_ff <= '0;
			rd_flg_ff <= '0;
		end else begin
			rd_id_ff <= nxt_rd_id;
			rd_dlc_ff <= nxt_rd_dlc;
			rd_dat_ff <= nxt_rd_dat;
			rd_flg_ff <= nxt_rd_flg;
		end
	end

	assign rd_id_o = rd_id_ff;
	assign rd_dlc_o = rd_dlc_ff;
	assign rd_data_o = rd_dat_ff;
	assign rd_flags_o = rd_flg_ff;
	assign rx_hit_o = hit_ff;
	assign tx_valid_o = tx_busy_ff;
	assign tx_id_o = tx_id_ff;
	assign tx_ide_o = tx_ide_ff;
	assign tx_rtr_o = tx_rtr_ff;
	assign tx_dlc_o = tx_dlc_ff;
	assign tx_data_o = tx_dat_ff;
	assign list_cnt_o = cnt_ff;

endmodule // dcn_msg_lists

// ### rtl/dcn_params.svh
// Constants for the dual-node message-object list block.
// Assumes inclusion by bare name from the design files.
`ifndef DCN_PARAMS_SVH
`define DCN_PARAMS_SVH

`define DCN_NUM_OBJ   64
`define DCN_NUM_NODE  2
`define DCN_ID_W      29
`define DCN_STD_W     11
`define DCN_DLC_W     4
`define DCN_DATA_W    64
`define DCN_FLAG_W    7

`endif

// ### rtl/dcn_pkg.sv
// Types for the dual-node message-object list block.
// Assumes dcn_params.svh is compiled alongside.
package dcn_pkg;

	typedef enum logic [1:0] {
		DCN_CMD_NOP    = 2'b00,
		DCN_CMD_APPEND = 2'b01,
		DCN_CMD_REMOVE = 2'b10
	} dcn_cmd_t;

	typedef enum logic [1:0] {
		DCN_OWN_NONE = 2'b00,
		DCN_OWN_N0   = 2'b01,
		DCN_OWN_N1   = 2'b10
	} dcn_own_t;

endpackage

// ### testbench/dcn_msg_lists_properties.sv
// Concurrent checks on the ports of the dual-node message-list block.
// Assumes one clock domain and is bound to every dcn_msg_lists instance.
`timescale 1ns/1ps
`include "dcn_params.svh"
module dcn_msg_lists_chk #(
	parameter int NUM_OBJ = 64,
	parameter int OBJ_W   = 6
)(
	input wire logic                 clk_i,          // Clock
	input wire logic                 sys_rst_i,      // Reset
	input wire logic                 cmd_valid_i,    // Command strobe
	input wire dcn_pkg::dcn_cmd_t    cmd_op_i,       // Command
	input wire logic                 cmd_node_i,     // Target node
	input wire logic                 rx_valid_i [2], // Frame in
	input wire logic                 rx_hit_o [2],   // Frame stored
	input wire logic                 tx_valid_o [2], // Frame offered
	input wire logic [`DCN_ID_W-1:0] tx_id_o [2],    // Tx identifier
	input wire logic                 tx_done_i [2],  // Frame sent
	input wire logic [OBJ_W:0]       list_cnt_o [2]  // List length
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_offer0;
		tx_valid_o[0] && !tx_done_i[0];
	endsequence
	sequence s_sent0;
		tx_valid_o[0] && tx_done_i[0];
	endsequence
	AST_POOL: assert property (int'(list_cnt_o[0]) + int'(list_cnt_o[1]) <= NUM_OBJ)
		else $error("lists hold more objects than the pool");
	AST_HIT0: assert property (rx_hit_o[0] |-> $past(rx_valid_i[0]))
		else $error("node 0 store without a frame");
	AST_HIT1: assert property (rx_hit_o[1] |-> $past(rx_valid_i[1]))
		else $error("node 1 store without a frame");
	AST_RX_EMPTY: assert property (rx_valid_i[0] && list_cnt_o[0] == 0 |=> !rx_hit_o[0])
		else $error("frame stored with empty list");
	AST_TX_HOLD: assert property (s_offer0 |=> tx_valid_o[0] && $stable(tx_id_o[0]))
		else $error("offered frame dropped or changed");
	AST_TX_DONE: assert property (s_sent0 |=> !tx_valid_o[0])
		else $error("offer kept after done");
	AST_TX_EMPTY: assert property (list_cnt_o[0] == 0 && !tx_valid_o[0] |=> !tx_valid_o[0])
		else $error("frame offered from empty list");
	AST_QUIET: assert property (!(cmd_valid_i && cmd_op_i != dcn_pkg::DCN_CMD_NOP) |=>
		$stable(list_cnt_o[0]) && $stable(list_cnt_o[1])) else $error("list changed without command");
	AST_GROW: assert property (cmd_valid_i && cmd_op_i == dcn_pkg::DCN_CMD_APPEND &&
		!cmd_node_i && list_cnt_o[0] == 0 |=> list_cnt_o[0] == 1) else $error("append miscounted");
endmodule // dcn_msg_lists_chk

bind dcn_msg_lists dcn_msg_lists_chk #(.NUM_OBJ(NUM_OBJ), .OBJ_W(OBJ_W)) u_chk (.*);

// ### testbench/dcn_node_model.sv
// Frame-level model of one node's bit engine beside the message-list block.
// Assumes the block's clock; done comes dly_i+1 cycles into each offer.
`timescale 1ns/1ps
`include "dcn_params.svh"
module dcn_node_model (
	input  wire logic                   clk_i,      // Clock
	input  wire logic [3:0]             dly_i,      // Send time
	output logic                        rx_valid_o, // Frame strobe
	output logic [`DCN_ID_W-1:0]        rx_id_o,    // Identifier
	output logic                        rx_ide_o,   // Extended
	output logic                        rx_rtr_o,   // Remote
	output logic [`DCN_DLC_W-1:0]       rx_dlc_o,   // Length
	output logic [`DCN_DATA_W-1:0]      rx_data_o,  // Payload
	input  wire logic                   rx_hit_i,   // Stored
	input  wire logic                   tx_valid_i, // Offer
	input  wire logic [`DCN_ID_W-1:0]   tx_id_i,    // Tx identifier
	input  wire logic                   tx_ide_i,   // Tx extended
	output logic                        tx_done_o   // Sent
);
	logic [63:0] sent [$];
	logic [3:0]  cnt = 4'h0;
	initial begin
		{rx_valid_o, rx_id_o, rx_ide_o, rx_rtr_o, rx_dlc_o, rx_data_o, tx_done_o} = '0;
	end
	// Whole frame in one strobe, both identifier formats
	task automatic send(input logic [28:0] id, input logic ide, rtr, input logic [63:0] d,
		output logic hit);
		@(posedge clk_i);
		#1;
		{rx_valid_o, rx_id_o, rx_ide_o, rx_rtr_o, rx_dlc_o, rx_data_o} = {1'b1, id, ide, rtr, 4'h8, d};
		@(posedge clk_i);
		#1;
		hit = rx_hit_i;
		rx_valid_o = 1'b0;
		// Released identifier and payload lines must not keep showing the last frame
		rx_id_o = ~rx_id_o;
		rx_data_o = ~rx_data_o;
	endtask
	always @(posedge clk_i) begin
		if (tx_valid_i && !tx_done_o) begin
			cnt <= (cnt == dly_i) ? 4'h0 : cnt + 4'h1;
			tx_done_o <= #1 (cnt == dly_i);
		end else begin
			tx_done_o <= #1 1'b0;
		end
		if (tx_valid_i && tx_done_o) sent.push_back({34'h0, tx_ide_i, tx_id_i});
	end
endmodule // dcn_node_model

// ### testbench/dcn_msg_lists_test.sv
// Self-checking bench for the dual-node message-list block.
// Assumes the package, checker and node model are compiled before it.
`timescale 1ns/1ps
module dcn_msg_lists_test;
	logic clk_i = 1'b0, sys_rst_i = 1'b1, cmd_valid_i = 1'b0, cmd_node_i = 1'b0, h;
	logic wr_valid_i = 1'b0, wr_ide_i = 1'b0, wr_rtr_i = 1'b0, wr_rx_en_i = 1'b0;
	logic wr_tx_req_i = 1'b0, wr_gw_en_i = 1'b0;
	dcn_pkg::dcn_cmd_t cmd_op_i = dcn_pkg::DCN_CMD_NOP;
	logic [5:0]  cmd_obj_i = 6'h00, wr_obj_i = 6'h00, wr_gw_dst_i = 6'h00, rd_obj_i = 6'h00;
	logic [28:0] wr_id_i = 29'h0, wr_mask_i = 29'h1FFF_FFFF, rd_id_o, rx_id_i [2], tx_id_o [2];
	logic [3:0]  wr_dlc_i = 4'h8, rd_dlc_o, dly [2] = '{4'h0, 4'h0}, rx_dlc_i [2], tx_dlc_o [2];
	logic [63:0] wr_data_i = 64'h0, rd_data_o, rx_data_i [2], tx_data_o [2];
	logic [6:0]  rd_flags_o, list_cnt_o [2];
	logic        rx_valid_i [2], rx_ide_i [2], rx_rtr_i [2], rx_hit_o [2], tx_valid_o [2];
	logic        tx_ide_o [2], tx_rtr_o [2], tx_done_i [2];
	int          num_errors = 0, samples_checked = 0;
	localparam logic [28:0] ID_A = 29'h0123_4567;

	dcn_msg_lists DUT (.*);
	for (genvar g = 0; g < 2; g++) begin : gn
		dcn_node_model u_node (.clk_i(clk_i), .dly_i(dly[g]), .rx_valid_o(rx_valid_i[g]),
			.rx_id_o(rx_id_i[g]), .rx_ide_o(rx_ide_i[g]), .rx_rtr_o(rx_rtr_i[g]),
			.rx_dlc_o(rx_dlc_i[g]), .rx_data_o(rx_data_i[g]), .rx_hit_i(rx_hit_o[g]),
			.tx_valid_i(tx_valid_o[g]), .tx_id_i(tx_id_o[g]), .tx_ide_i(tx_ide_o[g]),
			.tx_done_o(tx_done_i[g]));
	end
	always #10 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [63:0] e, g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic cnts(input logic [6:0] e0, e1);
		chk("list 0 count", 64'(e0), 64'(list_cnt_o[0]));
		chk("list 1 count", 64'(e1), 64'(list_cnt_o[1]));
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic cmd(input dcn_pkg::dcn_cmd_t op, input logic [5:0] o, input logic n);
		idle(1);
		{cmd_valid_i, cmd_op_i, cmd_obj_i, cmd_node_i} = {1'b1, op, o, n};
		idle(1);
		cmd_valid_i = 1'b0;
	endtask
	task automatic wr(input logic [5:0] o, input logic [28:0] id, input logic ide, rxe, txq, gwe,
		input logic [5:0] gd);
		idle(1);
		{wr_valid_i, wr_obj_i, wr_id_i, wr_ide_i, wr_rx_en_i} = {1'b1, o, id, ide, rxe};
		{wr_tx_req_i, wr_gw_en_i, wr_gw_dst_i, wr_data_i} = {txq, gwe, gd, 35'h0, id};
		idle(1);
		wr_valid_i = 1'b0;
	endtask
	task automatic rd(input logic [5:0] o);
		rd_obj_i = o;
		idle(2);
	endtask
	function automatic int sz(input int k);
		return k ? gn[1].u_node.sent.size() : gn[0].u_node.sent.size();
	endfunction
	task automatic wait_sent(input int k, n);
		for (int i = 0; i < 300 && sz(k) < n; i++) @(posedge clk_i);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		cnts(7'h00, 7'h00);
		rd(6'h3F);
		chk("flags obj63", 64'h0, 64'(rd_flags_o));
		wr(6'h03, 29'h0ABC_0003, 1'b1, 1'b1, 1'b1, 1'b0, 6'h00);
		gn[0].u_node.send(29'h0ABC_0003, 1'b1, 1'b0, 64'h11, h);
		chk("unowned store", 64'h0, 64'(h));
		idle(10);
		chk("unowned sent", 64'h0, 64'(sz(0)));
	endtask
	task automatic t_lists;
		cmd(dcn_pkg::DCN_CMD_APPEND, 6'h05, 1'b0);
		cmd(dcn_pkg::DCN_CMD_APPEND, 6'h06, 1'b0);
		cmd(dcn_pkg::DCN_CMD_APPEND, 6'h07, 1'b0);
		cmd(dcn_pkg::DCN_CMD_APPEND, 6'h09, 1'b1);
		cmd(dcn_pkg::DCN_CMD_APPEND, 6'h3F, 1'b1);
		cnts(7'h03, 7'h02);
		rd(6'h09);
		chk("owner obj9", 64'h2, 64'(rd_flags_o[6:5]));
		cmd(dcn_pkg::DCN_CMD_APPEND, 6'h3F, 1'b0);
		cnts(7'h04, 7'h01);
		cmd(dcn_pkg::DCN_CMD_REMOVE, 6'h3F, 1'b0);
		cnts(7'h03, 7'h01);
		cmd(dcn_pkg::DCN_CMD_REMOVE, 6'h3F, 1'b0);
		cmd(dcn_pkg::DCN_CMD_NOP, 6'h05, 1'b1);
		cnts(7'h03, 7'h01);
	endtask
	task automatic t_fifo;
		wr(6'h05, ID_A, 1'b1, 1'b1, 1'b0, 1'b0, 6'h00);
		wr(6'h06, ID_A, 1'b1, 1'b1, 1'b0, 1'b0, 6'h00);
		gn[0].u_node.send(ID_A, 1'b1, 1'b0, 64'hD1, h);
		chk("first store", 64'h1, 64'(h));
		gn[0].u_node.send(ID_A, 1'b1, 1'b0, 64'hD2, h);
		chk("second store", 64'h1, 64'(h));
		gn[1].u_node.send(ID_A, 1'b1, 1'b0, 64'hD9, h);
		chk("other node store", 64'h0, 64'(h));
		gn[0].u_node.send(ID_A, 1'b0, 1'b0, 64'hDA, h);
		chk("format store", 64'h0, 64'(h));
		rd(6'h05);
		chk("obj5 data", 64'hD1, rd_data_o);
		rd(6'h06);
		chk("obj6 data", 64'hD2, rd_data_o);
	endtask
	task automatic t_prio;
		dly[0] = 4'h9;
		wr(6'h07, 29'h0ABC_DEF0, 1'b1, 1'b0, 1'b1, 1'b0, 6'h00);
		wr(6'h05, 29'h1FFF_FFF0, 1'b1, 1'b0, 1'b1, 1'b0, 6'h00);
		wr(6'h06, {11'h012, 18'h0}, 1'b0, 1'b0, 1'b1, 1'b0, 6'h00);
		wait_sent(0, 3);
		chk("sent first", 64'({1'b1, 29'h0ABC_DEF0}), gn[0].u_node.sent[0]);
		chk("sent second", 64'({1'b0, 11'h012, 18'h0}), gn[0].u_node.sent[1]);
		chk("sent third", 64'({1'b1, 29'h1FFF_FFF0}), gn[0].u_node.sent[2]);
		idle(20);
		chk("no resend", 64'h3, 64'(sz(0)));
	endtask
	task automatic t_gateway;
		wr(6'h09, 29'h0, 1'b1, 1'b0, 1'b0, 1'b0, 6'h00);
		wr(6'h05, ID_A, 1'b1, 1'b1, 1'b0, 1'b1, 6'h09);
		gn[0].u_node.send(ID_A, 1'b1, 1'b1, 64'hD3, h);
		chk("gateway store", 64'h1, 64'(h));
		idle(1);
		chk("gateway offer", 64'h1, 64'(tx_valid_o[1]));
		chk("gateway tx data", 64'hD3, tx_data_o[1]);
		chk("gateway tx remote", 64'h1, 64'(tx_rtr_o[1]));
		chk("gateway tx length", 64'h8, 64'(tx_dlc_o[1]));
		wait_sent(1, 1);
		chk("gateway sent", 64'({1'b1, ID_A}), gn[1].u_node.sent[0]);
		rd(6'h09);
		chk("gateway data", 64'hD3, rd_data_o);
		chk("gateway read id", 64'(ID_A), 64'(rd_id_o));
		chk("gateway read length", 64'h8, 64'(rd_dlc_o));
		chk("gateway remote", 64'h1, 64'(rd_flags_o[3]));
		cmd(dcn_pkg::DCN_CMD_APPEND, 6'h03, 1'b1);
		wait_sent(1, 2);
		chk("late sent", 64'({1'b1, 29'h0ABC_0003}), gn[1].u_node.sent[1]);
	endtask
	task automatic give_verdict;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		idle(5000);
		num_errors++;
		$display("watchdog expired");
		give_verdict();
	end
	initial begin
		idle(16);
		sys_rst_i = 1'b0;
		t_reset();
		t_lists();
		t_fifo();
		t_prio();
		t_gateway();
		give_verdict();
	end
endmodule // dcn_msg_lists_test
